// ==== rtl/efc_conditioner.v ====
// e1 framer mode selection and fault conditioning
`include "efc_map.vh"
module efc_conditioner #(
    parameter FIFO_DEPTH = `EFC_FIFO_DEPTH,
    parameter FIFO_AW = 4
) (
    // clock and reset
    input wire i_core_clk,
    input wire i_reset,
    // configuration
    input wire [1:0] i_line_type,
    input wire i_cas_enable,
    input wire i_uplink_fail_ais,
    input wire [7:0] i_idle_code,
    input wire [7:0] i_cond_data,
    input wire [3:0] i_cond_abcd,
    input wire i_cfg_load,
    // fault status
    input wire i_line_los,
    input wire i_line_lof,
    input wire i_line_ais,
    input wire i_buf_overrun,
    input wire i_buf_underrun,
    input wire i_uplink_fail,
    // packet to line stream
    input wire i_pkt_valid,
    output wire o_pkt_ready,
    input wire [7:0] i_pkt_data,
    input wire [3:0] i_pkt_abcd,
    input wire i_pkt_slot_used,
    // line transmit
    output reg o_tx_valid,
    input wire i_tx_ready,
    output reg [7:0] o_tx_data,
    output reg [3:0] o_tx_abcd,
    // line to packet stream
    input wire i_rx_valid,
    input wire [7:0] i_rx_data,
    input wire [3:0] i_rx_abcd,
    output reg o_ip_valid,
    output reg [7:0] o_ip_data,
    output reg [3:0] o_ip_abcd,
    // framer configuration and status
    output reg o_crc4_mf,
    output reg o_cas_mf,
    output reg o_passthru,
    output reg [1:0] o_op_mode,
    output reg o_tx_cond_active,
    output reg o_ip_cond_active
);
    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    reg [1:0] line_type_reg;
    reg cas_en_reg;
    reg up_ais_reg;
    reg [7:0] idle_reg;
    reg [7:0] cdata_reg;
    reg [3:0] cabcd_reg;

    always @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            line_type_reg <= `EFC_LINE_CRC4_ON;
            cas_en_reg <= 1'b1;
            up_ais_reg <= 1'b0;
            idle_reg <= `EFC_IDLE_DEFAULT;
            cdata_reg <= `EFC_COND_DATA_DEFAULT;
            cabcd_reg <= `EFC_COND_ABCD_DEFAULT;
        end else if (i_cfg_load) begin
            line_type_reg <= i_line_type;
            cas_en_reg <= i_cas_enable;
            up_ais_reg <= i_uplink_fail_ais;
            idle_reg <= i_idle_code;
            cdata_reg <= i_cond_data;
            cabcd_reg <= i_cond_abcd;
        end
    end

    // ------------------------------------------------------------
    // framer mode decode
    // ------------------------------------------------------------
    wire unframed;
    assign unframed = (line_type_reg == `EFC_LINE_UNFRAMED);

    always @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_crc4_mf <= 1'b1;
            o_cas_mf <= 1'b1;
            o_passthru <= 1'b0;
            o_op_mode <= `EFC_OPM_FRAC_CAS;
        end else begin
            o_crc4_mf <= (line_type_reg == `EFC_LINE_CRC4_ON);
            o_passthru <= unframed;
            if (unframed) begin
                o_cas_mf <= 1'b0;
                o_op_mode <= `EFC_OPM_TRANSPARENT;
            end else if (cas_en_reg) begin
                o_cas_mf <= 1'b1;
                o_op_mode <= `EFC_OPM_FRAC_CAS;
            end else begin
                o_cas_mf <= 1'b0;
                o_op_mode <= `EFC_OPM_FRACTIONAL;
            end
        end
    end

    // ------------------------------------------------------------
    // fault qualification, live levels so recovery is immediate
    // ------------------------------------------------------------
    wire buf_fault;
    wire line_fault;
    wire tx_ais;
    wire tx_cond;
    assign buf_fault = i_buf_overrun || i_buf_underrun;
    assign line_fault = i_line_los || i_line_lof || i_line_ais;
    // unframed mode: buffer faults and los toward the line become ais; in any mode uplink fail becomes ais when up_ais_reg is set
    assign tx_ais = (unframed && (buf_fault || i_line_los)) ||
                    (i_uplink_fail && up_ais_reg);
    assign tx_cond = !unframed && (buf_fault ||
                     (i_uplink_fail && !up_ais_reg));

    // ------------------------------------------------------------
    // ais toward the ip path
    // ------------------------------------------------------------
    wire ip_ais;
    // unframed mode: los toward the ip path becomes ais
    assign ip_ais = unframed && i_line_los;

    // ------------------------------------------------------------
    // line-bound fifo
    // ------------------------------------------------------------
    wire [12:0] fifo_out;
    wire fifo_valid;
    efc_fifo #(
        .WIDTH(13),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_in_valid(i_pkt_valid),
        .o_in_ready(o_pkt_ready),
        .i_in_data({i_pkt_slot_used, i_pkt_abcd, i_pkt_data}),
        .o_out_valid(fifo_valid),
        .i_out_ready(i_tx_ready || !o_tx_valid),
        .o_out_data(fifo_out)
    );

    // ------------------------------------------------------------
    // transmit toward the e1 line
    // ------------------------------------------------------------
    wire take;
    assign take = fifo_valid && (i_tx_ready || !o_tx_valid);

    always @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_tx_valid <= 1'b0;
            o_tx_data <= 8'h00;
            o_tx_abcd <= 4'h0;
            o_tx_cond_active <= 1'b0;
        end else begin
            o_tx_cond_active <= tx_ais || tx_cond;
            if (take) begin
                o_tx_valid <= 1'b1;
                if (tx_ais) begin
                    o_tx_data <= `EFC_AIS_BYTE;
                    o_tx_abcd <= `EFC_AIS_ABCD;
                end else if (tx_cond) begin
                    o_tx_data <= cdata_reg;
                    o_tx_abcd <= cabcd_reg;
                end else if (!unframed && !fifo_out[12]) begin
                    o_tx_data <= idle_reg;
                    o_tx_abcd <= fifo_out[11:8];
                end else begin
                    o_tx_data <= fifo_out[7:0];
                    o_tx_abcd <= fifo_out[11:8];
                end
            end else if (i_tx_ready) begin
                o_tx_valid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // transmit toward the ip path
    // ------------------------------------------------------------
    always @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_ip_valid <= 1'b0;
            o_ip_data <= 8'h00;
            o_ip_abcd <= 4'h0;
            o_ip_cond_active <= 1'b0;
        end else begin
            o_ip_valid <= i_rx_valid;
            o_ip_cond_active <= ip_ais ||
                                (!unframed && line_fault);
            if (i_rx_valid) begin
                if (ip_ais) begin
                    o_ip_data <= `EFC_AIS_BYTE;
                    o_ip_abcd <= `EFC_AIS_ABCD;
                end else if (!unframed && line_fault) begin
                    o_ip_data <= cdata_reg;
                    o_ip_abcd <= cabcd_reg;
                end else begin
                    o_ip_data <= i_rx_data;
                    o_ip_abcd <= i_rx_abcd;
                end
            end
        end
    end
endmodule

// ==== rtl/efc_fifo.v ====
// synchronous fifo for the line-bound data path
module efc_fifo #(
    parameter WIDTH = 13,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire i_core_clk,
    input wire i_reset,
    // write side
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    // read side
    output wire o_out_valid,
    input wire i_out_ready,
    output reg [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    reg out_full_reg;
    wire push;
    wire pop_mem;
    wire load_out;
    wire [AW:0] held;

    // words in memory plus the output register
    assign held = count_reg + {{AW{1'b0}}, out_full_reg};
    assign o_in_ready = (held != DEPTH[AW:0]);
    assign push = i_in_valid && o_in_ready;
    assign o_out_valid = out_full_reg;
    // output register refills when empty or being taken
    assign load_out = (count_reg != {(AW+1){1'b0}}) &&
                      (!out_full_reg || i_out_ready);
    assign pop_mem = load_out;

    always @(posedge i_core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

    always @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            out_full_reg <= 1'b0;
            o_out_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop_mem) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
                o_out_data <= mem_reg[rd_ptr_reg];
                out_full_reg <= 1'b1;
            end else if (i_out_ready) begin
                out_full_reg <= 1'b0;
            end
            case ({push, pop_mem})
                2'b10: count_reg <= count_reg + 1'b1;
                2'b01: count_reg <= count_reg - 1'b1;
                default: count_reg <= count_reg;
            endcase
        end
    end
endmodule

// ==== rtl/efc_map.vh ====
// constants for the e1 framer conditioning block
`ifndef EFC_MAP_VH
`define EFC_MAP_VH
// line type codes
`define EFC_LINE_UNFRAMED 2'h0
`define EFC_LINE_CRC4_ON 2'h1
`define EFC_LINE_CRC4_OFF 2'h2
// operation mode codes
`define EFC_OPM_TRANSPARENT 2'h0
`define EFC_OPM_FRACTIONAL 2'h1
`define EFC_OPM_FRAC_CAS 2'h2
// reset defaults, ais pattern and fifo depth
`define EFC_IDLE_DEFAULT 8'h7E
`define EFC_COND_DATA_DEFAULT 8'hFF
`define EFC_COND_ABCD_DEFAULT 4'h1
`define EFC_AIS_BYTE 8'hFF
`define EFC_AIS_ABCD 4'hF
`define EFC_FIFO_DEPTH 16
`endif

// ==== verification/efc_cond_asserts.sv ====
// assertions for the e1 framer conditioning block
module efc_cond_asserts (
    input wire i_core_clk,
    input wire i_reset,
    input wire i_cfg_load,
    input wire i_cas_enable,
    input wire [1:0] i_line_type,
    input wire i_line_los, i_line_lof, i_line_ais, i_rx_valid,
    input wire [7:0] i_rx_data, o_tx_data, o_ip_data,
    input wire [3:0] i_rx_abcd, o_tx_abcd, o_ip_abcd,
    input wire o_tx_valid, o_ip_valid, o_ip_cond_active, o_passthru,
    input wire o_crc4_mf, o_cas_mf,
    input wire [1:0] o_op_mode
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    wire ld = i_cfg_load;
    wire fr = i_line_type != 2'h0;
    wire lf = i_line_los | i_line_lof | i_line_ais;
    a_crc4_on: assert property (ld && i_line_type == 2'h1 ##1 !ld
        |-> ##1 o_crc4_mf && !o_passthru) else $error("crc4 mode");
    a_crc4_off: assert property (ld && i_line_type == 2'h2 ##1 !ld
        |-> ##1 !o_crc4_mf && !o_passthru) else $error("crc4 off mode");
    a_cas_mode: assert property (ld && fr && i_cas_enable ##1 !ld
        |-> ##1 o_cas_mf && o_op_mode == 2'h2) else $error("cas mode");
    a_frac_mode: assert property (ld && fr && !i_cas_enable ##1 !ld
        |-> ##1 !o_cas_mf && o_op_mode == 2'h1) else $error("frac mode");
    a_unframed_mode: assert property (ld && !fr ##1 !ld
        |-> ##1 o_passthru && o_op_mode == 2'h0) else $error("unframed");
    a_ip_subst: assert property (i_rx_valid && lf && !o_passthru
        |=> o_ip_valid && o_ip_cond_active) else $error("ip subst");
    a_ip_clear: assert property (i_rx_valid && !lf |=> o_ip_valid
        && !o_ip_cond_active && o_ip_data == $past(i_rx_data)
        && o_ip_abcd == $past(i_rx_abcd)) else $error("ip data");
    a_tx_ais: assert property ($rose(o_tx_valid) && o_passthru
        && $past(i_line_los) |-> o_tx_data == 8'hFF && o_tx_abcd == 4'hF)
        else $error("tx ais");
    a_ip_ais: assert property (i_rx_valid && i_line_los
        && o_passthru && !$past(ld) |=> o_ip_data == 8'hFF
        && o_ip_abcd == 4'hF) else $error("ip ais");
endmodule
bind efc_conditioner efc_cond_asserts u_efc_cond_asserts (.*);

// ==== verification/efc_line_model.sv ====
// far-side line equipment model: sinks tx bytes, sources rx bytes
module efc_line_model (
    // control
    input wire i_core_clk,
    input wire i_stall,
    input wire i_slow,
    // stream from the block
    input wire i_tx_valid,
    input wire [7:0] i_tx_data,
    input wire [3:0] i_tx_abcd,
    output logic o_tx_ready = 1'h0,
    // stream toward the block
    output logic o_rx_valid = 1'h0,
    output logic [7:0] o_rx_data = 8'h00,
    output logic [3:0] o_rx_abcd = 4'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] got [$];
    always @(posedge i_core_clk)
        if (i_tx_valid && o_tx_ready)
            got.push_back({i_tx_abcd, i_tx_data});
    // slow mode accepts every other cycle
    always @(negedge i_core_clk)
        o_tx_ready <= !i_stall && (!i_slow || !o_tx_ready);
    task automatic drive(input logic [7:0] d, input logic [3:0] a);
        @(negedge i_core_clk);
        o_rx_valid = 1'h1;
        o_rx_data = d;
        o_rx_abcd = a;
        @(negedge i_core_clk);
        o_rx_valid = 1'h0;
        // released lines show the inverse, not the stale byte
        o_rx_data = ~d;
        o_rx_abcd = ~a;
    endtask
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the e1 framer conditioning block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 1'h0, i_reset = 1'h1, i_cfg_load = 1'h0;
    logic i_cas_enable = 1'h1, i_uplink_fail_ais = 1'h0, i_pkt_valid = 1'h0;
    logic i_pkt_slot_used = 1'h1, stall = 1'h0, slow = 1'h0;
    logic i_line_los, i_line_lof, i_line_ais, i_buf_overrun, i_buf_underrun;
    logic i_uplink_fail, i_tx_ready, i_rx_valid, o_pkt_ready, o_tx_valid;
    logic o_ip_valid, o_crc4_mf, o_cas_mf, o_passthru, o_tx_cond_active;
    logic o_ip_cond_active;
    logic [1:0] i_line_type = 2'h1, o_op_mode;
    logic [7:0] i_idle_code = 8'h7E, i_cond_data = 8'hFF, i_pkt_data = 8'h00;
    logic [7:0] i_rx_data, o_tx_data, o_ip_data;
    logic [3:0] i_cond_abcd = 4'h1, i_pkt_abcd = 4'h3, i_rx_abcd, o_tx_abcd;
    logic [3:0] o_ip_abcd;
    logic [12:0] mt [6] = '{13'h0004, 13'h0004, 13'h0011, 13'h001A,
        13'h0001, 13'h000A};
    logic [5:0] tf [9] = '{6'h00, 6'h04, 6'h02, 6'h01, 6'h20, 6'h00,
        6'h20, 6'h02, 6'h00};
    logic [11:0] te [9] = '{12'h312, 12'h6A5, 12'h6A5, 12'h6A5, 12'h312,
        12'h312, 12'hFFF, 12'hFFF, 12'h312};
    logic [5:0] rf [4] = '{6'h20, 6'h10, 6'h08, 6'h00};
    logic [12:0] re [4] = '{13'h16A5, 13'h16A5, 13'h16A5, 13'h1955};
    int errors = 0, cmp_count = 0, n, k;
    always #20 i_core_clk = ~i_core_clk;
    efc_conditioner u_efc_conditioner (.*);
    efc_line_model u_efc_line_model (.i_core_clk(i_core_clk),
        .i_stall(stall), .i_slow(slow), .i_tx_valid(o_tx_valid),
        .i_tx_data(o_tx_data), .i_tx_abcd(o_tx_abcd), .o_tx_ready(i_tx_ready),
        .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
        .o_rx_abcd(i_rx_abcd));
    task automatic chk(input string s, input logic [12:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic bail();
        errors++;
        complete_run();
    endtask
    task automatic set_flt(input logic [5:0] f);
        {i_line_los, i_line_lof, i_line_ais, i_buf_overrun, i_buf_underrun,
            i_uplink_fail} = f;
    endtask
    task automatic cfg(input logic [1:0] t, input logic c, m);
        @(negedge i_core_clk);
        i_line_type = t;
        i_cas_enable = c;
        i_uplink_fail_ais = m;
        i_cfg_load = 1'h1;
        @(negedge i_core_clk);
        i_cfg_load = 1'h0;
        repeat (2) @(negedge i_core_clk);
    endtask
    task automatic push(input logic [7:0] d, input logic u);
        @(negedge i_core_clk);
        i_pkt_data = d;
        i_pkt_slot_used = u;
        i_pkt_valid = 1'h1;
        for (n = 0; n < 40 && o_pkt_ready !== 1'h1; n++)
            @(negedge i_core_clk);
        if (n == 40)
            bail();
        @(negedge i_core_clk);
        i_pkt_valid = 1'h0;
    endtask
    task automatic pop(input logic [11:0] e, m);
        for (n = 0; n < 40 && u_efc_line_model.got.size() == 0; n++)
            @(negedge i_core_clk);
        if (n == 40)
            bail();
        chk("tx", {1'h0, u_efc_line_model.got.pop_front() & m}, {1'h0, e & m});
    endtask
    task automatic rx(input logic [12:0] e);
        u_efc_line_model.drive(8'h55, 4'h9);
        chk("ip", {o_ip_valid, o_ip_abcd, o_ip_data}, e);
    endtask
    function automatic logic [12:0] mode();
        return {8'h00, o_crc4_mf, o_cas_mf, o_passthru, o_op_mode};
    endfunction
    initial begin
        set_flt(6'h00);
        repeat (4) @(negedge i_core_clk);
        i_reset = 1'h0;
        chk("mode", mode(), 13'h001A);
        push(8'h12, 1'h0);
        pop(12'h07E, 12'h0FF);
        set_flt(6'h20);
        rx(13'h11FF);
        set_flt(6'h00);
        i_idle_code = 8'h3C;
        i_cond_data = 8'hA5;
        i_cond_abcd = 4'h6;
        for (int i = 0; i < 6; i++) begin
            cfg(2'(i / 2), 1'(i % 2), 1'h0);
            chk("mode", mode(), mt[i]);
        end
        cfg(2'h1, 1'h1, 1'h0);
        for (int i = 0; i < 4; i++) begin
            set_flt(rf[i]);
            rx(re[i]);
        end
        for (int i = 0; i < 9; i++) begin
            if (i == 6)
                cfg(2'h0, 1'h1, 1'h0);
            set_flt(tf[i]);
            push(8'h12, 1'h1);
            pop(te[i], 12'hFFF);
            chk("tx cond", {12'h000, o_tx_cond_active},
                {12'h000, te[i] != 12'h312});
        end
        set_flt(6'h10);
        rx(13'h1955);
        set_flt(6'h20);
        rx(13'h1FFF);
        cfg(2'h1, 1'h1, 1'h1);
        set_flt(6'h01);
        push(8'h12, 1'h1);
        pop(12'hFFF, 12'hFFF);
        chk("tx cond", {12'h000, o_tx_cond_active}, 13'h0001);
        set_flt(6'h00);
        stall = 1'h1;
        for (k = 0; k < 24 && o_pkt_ready === 1'h1; k++)
            push(8'(k), 1'h1);
        chk("fill", 13'(k), 13'h0011);
        stall = 1'h0;
        slow = 1'h1;
        for (int j = 0; j < k; j++)
            pop({4'h3, 8'(j)}, 12'hFFF);
        complete_run();
    end
endmodule
